// File: pmc_pkg.sv
// Shared constants and carrier types for the performance-monitoring counters
package pmc_pkg;

  localparam int CNT_W = 32;
  localparam int SEC_W = 16;
  localparam int LINE_ACC_W = 24;
  localparam int PATH_ACC_W = 16;
  localparam int RUN_W = 4;

  localparam logic [7:0] REI_OC48_MAX = 8'h00ff;
  localparam logic [7:0] REI_PER_STS = 8'h0008;
  localparam logic [3:0] B3_MAX = 4'h8;
  localparam logic [PATH_ACC_W-1:0] PATH_SES_K = 16'h0960;
  localparam logic [RUN_W-1:0] UNAV_RUN = 4'ha;
  localparam logic [RUN_W-1:0] RUN_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [SEC_W-1:0] SEC_RST = 16'h0000;
  localparam logic [LINE_ACC_W-1:0] LINE_ACC_RST = 24'h00_0000;
  localparam logic [PATH_ACC_W-1:0] PATH_ACC_RST = 16'h0000;

  typedef struct packed {
    logic pos_det;
    logic neg_det;
    logic pos_gen;
    logic neg_gen;
  } pmc_just_t;

  typedef struct packed {
    logic rei_valid;
    logic [7:0] rei_count;
    logic rdi_defect;
    logic rfi_failure;
  } pmc_line_in_t;

  typedef struct packed {
    logic b3_valid;
    logic [3:0] b3_count;
    logic ais_defect;
    logic lop_defect;
    logic ais_fail;
    logic lop_fail;
    logic uneq_fail;
    logic tim_fail;
    logic rdi_support;
  } pmc_path_in_t;

  typedef struct packed {
    logic [CNT_W-1:0] violation;
    logic [SEC_W-1:0] errored;
    logic [SEC_W-1:0] severe;
    logic [SEC_W-1:0] unavailable;
    logic [SEC_W-1:0] failure;
  } pmc_layer_cnt_t;

  typedef struct packed {
    logic [CNT_W-1:0] pos_justify_detected_count;
    logic [CNT_W-1:0] neg_justify_detected_count;
    logic [CNT_W-1:0] pos_justify_generated_count;
    logic [CNT_W-1:0] neg_justify_generated_count;
    pmc_layer_cnt_t far_line;
    pmc_layer_cnt_t near_path;
    pmc_layer_cnt_t far_path;
  } pmc_counts_t;

  typedef enum logic {
    PMC_AVAIL,
    PMC_UNAVAIL
  } pmc_avail_e_t;

  typedef struct packed {
    pmc_avail_e_t mode;
    logic [RUN_W-1:0] run;
    logic [RUN_W-1:0] uas_add;
  } pmc_unav_st_t;

  typedef struct packed {
    pmc_counts_t cnt;
    logic [LINE_ACC_W-1:0] line_acc;
    logic line_rdi_seen;
    logic [PATH_ACC_W-1:0] np_acc;
    logic np_def_seen;
    logic [PATH_ACC_W-1:0] fp_acc;
    logic fp_def_seen;
    logic rfi_prev;
    logic np_fail_prev;
    logic fp_fail_prev;
    logic line_eval;
    logic path_eval;
    logic fl_ses;
    logic np_ses;
    logic fp_ses;
  } pmc_main_st_t;

endpackage

// File: pmc_unavail.sv
// Availability tracker: ten-second onset rule and unavailable-second credit
`timescale 1ns/10ps
`default_nettype none
module pmc_unavail (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic eval,
  input wire logic ses,
  output logic unavailable,
  output logic [pmc_pkg::RUN_W-1:0] uas_add
);

  pmc_pkg::pmc_unav_st_t st_q;
  pmc_pkg::pmc_unav_st_t st_d;

  // Seconds are held pending until the run decides which side they belong to,
  // so the counter only ever moves upward.
  always_comb begin
    st_d = st_q;
    st_d.uas_add = pmc_pkg::RUN_RST;
    if (eval) begin
      unique case (st_q.mode)
        pmc_pkg::PMC_AVAIL: begin
          if (!ses) begin
            st_d.run = pmc_pkg::RUN_RST;
          end else if (st_q.run == pmc_pkg::UNAV_RUN - 4'h1) begin
            st_d.mode = pmc_pkg::PMC_UNAVAIL;
            st_d.run = pmc_pkg::RUN_RST;
            st_d.uas_add = pmc_pkg::UNAV_RUN;
          end else begin
            st_d.run = st_q.run + 4'h1;
          end
        end
        pmc_pkg::PMC_UNAVAIL: begin
          if (ses) begin
            st_d.uas_add = st_q.run + 4'h1;
            st_d.run = pmc_pkg::RUN_RST;
          end else if (st_q.run == pmc_pkg::UNAV_RUN - 4'h1) begin
            // Clean run complete: it started the available time, not counted
            st_d.mode = pmc_pkg::PMC_AVAIL;
            st_d.run = pmc_pkg::RUN_RST;
          end else begin
            st_d.run = st_q.run + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q.mode <= pmc_pkg::PMC_AVAIL;
      st_q.run <= pmc_pkg::RUN_RST;
      st_q.uas_add <= pmc_pkg::RUN_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign unavailable = (st_q.mode == pmc_pkg::PMC_UNAVAIL);
  assign uas_add = st_q.uas_add;

endmodule // pmc_unavail
`default_nettype wire

// File: pmc_counters.sv
// Path and line performance-monitoring counters for one STS path
//
// How it works
// R1: Count each detected positive pointer justification on the path.
// R2: Count each detected negative pointer justification on the path.
// R3: Count each positive pointer justification this end generates.
// R4: Count each negative pointer justification this end generates.
// R5: Far-end line violations grow by the error number REI-L reports.
// R6: REI-L accepted up to 8 times n, or 255 at OC-48.
// R7: Far-end line errored second: any remote line error or RDI-L.
// R8: Far-end line severe second: errors reach threshold K, or RDI-L.
// R9: Far-end line unavailable after ten severe seconds, back after ten clean.
// R10: Far-end line failure counted once, when RFI-L is declared.
// R11: Path counters hold still unless intermediate path monitoring is on.
// R12: Near-end path violations grow by B3 errors, at most eight a frame.
// R13: Near-end path errored second: any B3 error, AIS-P or LOP-P.
// R14: Near-end path severe second: 2400 errors or more, AIS-P or LOP-P.
// R15: Near-end path unavailable after ten severe seconds, back after ten clean.
// R16: Near-end path failure event counted when any path failure is declared.
// R17: Far-end path violations and errored seconds mirror the near-end ones.
// R18: Far-end path severe second: 2400 errors or more, AIS-P or LOP-P.
// R19: Far-end path unavailable after ten severe seconds, back after ten clean.
// R20: Far-end path failure event counted when any path failure is declared.
// R21: Second qualifications judged at each one-second tick on that second's totals.
`timescale 1ns/10ps
`default_nettype none
module pmc_counters (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic sec_tick,
  input wire pmc_pkg::pmc_just_t just,
  input wire logic oc48_mode,
  input wire logic [7:0] sts_n,
  input wire pmc_pkg::pmc_line_in_t line_in,
  input wire logic [pmc_pkg::LINE_ACC_W-1:0] far_line_ses_threshold,
  input wire logic intermediate_path_monitor_enable,
  input wire pmc_pkg::pmc_path_in_t near_path_in,
  input wire pmc_pkg::pmc_path_in_t far_path_in,
  output pmc_pkg::pmc_counts_t counts,
  output logic far_line_unavailable,
  output logic near_path_unavailable,
  output logic far_path_unavailable
);

  pmc_pkg::pmc_main_st_t st_q;
  pmc_pkg::pmc_main_st_t st_d;

  logic fl_unav;
  logic np_unav;
  logic fp_unav;
  logic [pmc_pkg::RUN_W-1:0] fl_uas_add;
  logic [pmc_pkg::RUN_W-1:0] np_uas_add;
  logic [pmc_pkg::RUN_W-1:0] fp_uas_add;

  // Largest REI-L value taken as genuine for the current rate
  function automatic logic [7:0] rei_cap(input logic oc48, input logic [7:0] n);
    logic [15:0] prod;
    prod = 16'h0000;
    prod = {8'h00, n} * {8'h00, pmc_pkg::REI_PER_STS};
    if (oc48) begin
      rei_cap = pmc_pkg::REI_OC48_MAX;
    end else if (prod > {8'h00, pmc_pkg::REI_OC48_MAX}) begin
      rei_cap = pmc_pkg::REI_OC48_MAX;
    end else begin
      rei_cap = prod[7:0];
    end
  endfunction

  // Out-of-range reports are clamped rather than dropped
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] cap);
    clamp8 = (v > cap) ? cap : v;
  endfunction

  function automatic logic [pmc_pkg::LINE_ACC_W-1:0] sat_line(
    input logic [pmc_pkg::LINE_ACC_W-1:0] a,
    input logic [7:0] b
  );
    logic [pmc_pkg::LINE_ACC_W:0] s;
    s = {1'b0, a} + {{pmc_pkg::LINE_ACC_W-7{1'b0}}, b};
    sat_line = s[pmc_pkg::LINE_ACC_W] ? {pmc_pkg::LINE_ACC_W{1'b1}} :
               s[pmc_pkg::LINE_ACC_W-1:0];
  endfunction

  // Per-second path totals saturate; the 2400 compare and the errored-second test depend on them
  function automatic logic [pmc_pkg::PATH_ACC_W-1:0] sat_path(
    input logic [pmc_pkg::PATH_ACC_W-1:0] a,
    input logic [3:0] b
  );
    logic [pmc_pkg::PATH_ACC_W:0] s;
    s = {1'b0, a} + {{pmc_pkg::PATH_ACC_W-3{1'b0}}, b};
    sat_path = s[pmc_pkg::PATH_ACC_W] ? {pmc_pkg::PATH_ACC_W{1'b1}} :
               s[pmc_pkg::PATH_ACC_W-1:0];
  endfunction

  function automatic logic [3:0] b3_errs(input pmc_pkg::pmc_path_in_t p);
    b3_errs = 4'h0;
    if (p.b3_valid) begin
      b3_errs = (p.b3_count > pmc_pkg::B3_MAX) ? pmc_pkg::B3_MAX : p.b3_count;
    end
  endfunction

  function automatic logic path_fail(input pmc_pkg::pmc_path_in_t p);
    path_fail = p.ais_fail | p.lop_fail | p.uneq_fail | p.tim_fail | p.rdi_support;
  endfunction

  function automatic logic path_defect(input pmc_pkg::pmc_path_in_t p);
    path_defect = p.ais_defect | p.lop_defect;
  endfunction

  function automatic logic [pmc_pkg::SEC_W-1:0] add_uas(
    input logic [pmc_pkg::SEC_W-1:0] c,
    input logic [pmc_pkg::RUN_W-1:0] a
  );
    add_uas = c + {{pmc_pkg::SEC_W-pmc_pkg::RUN_W{1'b0}}, a};
  endfunction

  always_comb begin
    logic [7:0] rei_now;
    logic [3:0] np_now;
    logic [3:0] fp_now;
    logic [pmc_pkg::LINE_ACC_W-1:0] line_tot;
    logic [pmc_pkg::PATH_ACC_W-1:0] np_tot;
    logic [pmc_pkg::PATH_ACC_W-1:0] fp_tot;
    logic line_rdi;
    logic np_def;
    logic fp_def;
    logic np_fail;
    logic fp_fail;
    rei_now = 8'h00;
    np_now = 4'h0;
    fp_now = 4'h0;
    line_tot = pmc_pkg::LINE_ACC_RST;
    np_tot = pmc_pkg::PATH_ACC_RST;
    fp_tot = pmc_pkg::PATH_ACC_RST;
    line_rdi = 1'b0;
    np_def = 1'b0;
    fp_def = 1'b0;
    np_fail = 1'b0;
    fp_fail = 1'b0;
    st_d = st_q;
    st_d.line_eval = 1'b0;
    st_d.path_eval = 1'b0;

    // Pointer justification counts
    if (just.pos_det) begin
      st_d.cnt.pos_justify_detected_count = st_q.cnt.pos_justify_detected_count + 32'h0000_0001; // R1
    end
    if (just.neg_det) begin
      st_d.cnt.neg_justify_detected_count = st_q.cnt.neg_justify_detected_count + 32'h0000_0001; // R2
    end
    if (just.pos_gen) begin
      st_d.cnt.pos_justify_generated_count = st_q.cnt.pos_justify_generated_count + 32'h0000_0001; // R3
    end
    if (just.neg_gen) begin
      st_d.cnt.neg_justify_generated_count = st_q.cnt.neg_justify_generated_count + 32'h0000_0001; // R4
    end

    // Far-end line layer
    if (line_in.rei_valid) begin
      rei_now = clamp8(line_in.rei_count, rei_cap(oc48_mode, sts_n)); // R6
    end
    st_d.cnt.far_line.violation = st_q.cnt.far_line.violation + {24'h00_0000, rei_now}; // R5
    line_tot = sat_line(st_q.line_acc, rei_now);
    line_rdi = st_q.line_rdi_seen | line_in.rdi_defect;
    st_d.line_acc = line_tot;
    st_d.line_rdi_seen = line_rdi;
    // Rising edge only, so an event is charged to the period it starts in
    if (line_in.rfi_failure && !st_q.rfi_prev) begin
      st_d.cnt.far_line.failure = st_q.cnt.far_line.failure + 16'h0001; // R10
    end
    st_d.rfi_prev = line_in.rfi_failure;

    // Path layers, frozen while monitoring is off
    if (intermediate_path_monitor_enable) begin // R11
      np_now = b3_errs(near_path_in);
      fp_now = b3_errs(far_path_in);
      st_d.cnt.near_path.violation = st_q.cnt.near_path.violation + {28'h000_0000, np_now}; // R12
      st_d.cnt.far_path.violation = st_q.cnt.far_path.violation + {28'h000_0000, fp_now}; // R17
      np_tot = sat_path(st_q.np_acc, np_now);
      fp_tot = sat_path(st_q.fp_acc, fp_now);
      np_def = st_q.np_def_seen | path_defect(near_path_in);
      fp_def = st_q.fp_def_seen | path_defect(far_path_in);
      st_d.np_acc = np_tot;
      st_d.fp_acc = fp_tot;
      st_d.np_def_seen = np_def;
      st_d.fp_def_seen = fp_def;
      np_fail = path_fail(near_path_in);
      fp_fail = path_fail(far_path_in);
      if (np_fail && !st_q.np_fail_prev) begin
        st_d.cnt.near_path.failure = st_q.cnt.near_path.failure + 16'h0001; // R16
      end
      if (fp_fail && !st_q.fp_fail_prev) begin
        st_d.cnt.far_path.failure = st_q.cnt.far_path.failure + 16'h0001; // R20
      end
      st_d.np_fail_prev = np_fail;
      st_d.fp_fail_prev = fp_fail;
    end

    // Second boundary: judge the closing second, including this cycle's input
    if (sec_tick) begin // R21
      st_d.line_eval = 1'b1;
      st_d.fl_ses = (line_tot >= far_line_ses_threshold) || line_rdi; // R8
      if ((line_tot != pmc_pkg::LINE_ACC_RST) || line_rdi) begin
        st_d.cnt.far_line.errored = st_q.cnt.far_line.errored + 16'h0001; // R7
      end
      if (st_d.fl_ses) begin
        st_d.cnt.far_line.severe = st_q.cnt.far_line.severe + 16'h0001; // R8
      end
      st_d.line_acc = pmc_pkg::LINE_ACC_RST;
      st_d.line_rdi_seen = 1'b0;
      if (intermediate_path_monitor_enable) begin // R11
        st_d.path_eval = 1'b1;
        st_d.np_ses = (np_tot >= pmc_pkg::PATH_SES_K) || np_def; // R14
        st_d.fp_ses = (fp_tot >= pmc_pkg::PATH_SES_K) || fp_def; // R18
        if ((np_tot != pmc_pkg::PATH_ACC_RST) || np_def) begin
          st_d.cnt.near_path.errored = st_q.cnt.near_path.errored + 16'h0001; // R13
        end
        if ((fp_tot != pmc_pkg::PATH_ACC_RST) || fp_def) begin
          st_d.cnt.far_path.errored = st_q.cnt.far_path.errored + 16'h0001; // R17
        end
        if (st_d.np_ses) begin
          st_d.cnt.near_path.severe = st_q.cnt.near_path.severe + 16'h0001; // R14
        end
        if (st_d.fp_ses) begin
          st_d.cnt.far_path.severe = st_q.cnt.far_path.severe + 16'h0001; // R18
        end
      end
      st_d.np_acc = pmc_pkg::PATH_ACC_RST;
      st_d.fp_acc = pmc_pkg::PATH_ACC_RST;
      st_d.np_def_seen = 1'b0;
      st_d.fp_def_seen = 1'b0;
    end

    // Unavailable seconds credited as the trackers release them
    st_d.cnt.far_line.unavailable = add_uas(st_q.cnt.far_line.unavailable, fl_uas_add); // R9
    if (intermediate_path_monitor_enable) begin // R11
      st_d.cnt.near_path.unavailable = add_uas(st_q.cnt.near_path.unavailable, np_uas_add); // R15
      st_d.cnt.far_path.unavailable = add_uas(st_q.cnt.far_path.unavailable, fp_uas_add); // R19
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q.cnt.pos_justify_detected_count <= pmc_pkg::CNT_RST;
      st_q.cnt.neg_justify_detected_count <= pmc_pkg::CNT_RST;
      st_q.cnt.pos_justify_generated_count <= pmc_pkg::CNT_RST;
      st_q.cnt.neg_justify_generated_count <= pmc_pkg::CNT_RST;
      st_q.cnt.far_line <= '{pmc_pkg::CNT_RST, pmc_pkg::SEC_RST, pmc_pkg::SEC_RST,
                             pmc_pkg::SEC_RST, pmc_pkg::SEC_RST};
      st_q.cnt.near_path <= '{pmc_pkg::CNT_RST, pmc_pkg::SEC_RST, pmc_pkg::SEC_RST,
                              pmc_pkg::SEC_RST, pmc_pkg::SEC_RST};
      st_q.cnt.far_path <= '{pmc_pkg::CNT_RST, pmc_pkg::SEC_RST, pmc_pkg::SEC_RST,
                             pmc_pkg::SEC_RST, pmc_pkg::SEC_RST};
      st_q.line_acc <= pmc_pkg::LINE_ACC_RST;
      st_q.line_rdi_seen <= 1'b0;
      st_q.np_acc <= pmc_pkg::PATH_ACC_RST;
      st_q.np_def_seen <= 1'b0;
      st_q.fp_acc <= pmc_pkg::PATH_ACC_RST;
      st_q.fp_def_seen <= 1'b0;
      st_q.rfi_prev <= 1'b0;
      st_q.np_fail_prev <= 1'b0;
      st_q.fp_fail_prev <= 1'b0;
      st_q.line_eval <= 1'b0;
      st_q.path_eval <= 1'b0;
      st_q.fl_ses <= 1'b0;
      st_q.np_ses <= 1'b0;
      st_q.fp_ses <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Trackers see the judged second one cycle after the tick
  pmc_unavail u_far_line (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .eval(st_q.line_eval),
    .ses(st_q.fl_ses),
    .unavailable(fl_unav),
    .uas_add(fl_uas_add)
  );

  pmc_unavail u_near_path (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .eval(st_q.path_eval),
    .ses(st_q.np_ses),
    .unavailable(np_unav),
    .uas_add(np_uas_add)
  );

  pmc_unavail u_far_path (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .eval(st_q.path_eval),
    .ses(st_q.fp_ses),
    .unavailable(fp_unav),
    .uas_add(fp_uas_add)
  );

  assign counts = st_q.cnt;
  assign far_line_unavailable = fl_unav;
  assign near_path_unavailable = np_unav;
  assign far_path_unavailable = fp_unav;

endmodule // pmc_counters
`default_nettype wire

// File: pmc_counters_sva.sv
// Checker for the performance-monitoring counter block
`timescale 1ns/10ps
`default_nettype none
module pmc_counters_sva (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic sec_tick,
  input wire pmc_pkg::pmc_just_t just,
  input wire pmc_pkg::pmc_line_in_t line_in,
  input wire logic intermediate_path_monitor_enable,
  input wire pmc_pkg::pmc_path_in_t near_path_in,
  input wire pmc_pkg::pmc_counts_t counts,
  input wire logic near_path_unavailable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [31:0] b3_clamped;
  assign b3_clamped = (near_path_in.b3_count > pmc_pkg::B3_MAX) ?
    32'(pmc_pkg::B3_MAX) : 32'(near_path_in.b3_count);
  sequence s_rdi_tick;
    clk_en && sec_tick && line_in.rdi_defect;
  endsequence
  sequence s_line_judged;
    ##1 (counts.far_line.errored == $past(counts.far_line.errored) + 16'h0001) &&
    (counts.far_line.severe == $past(counts.far_line.severe) + 16'h0001);
  endsequence
  AST_POS_DET: assert property (clk_en |=>
    counts.pos_justify_detected_count == $past(counts.pos_justify_detected_count) +
    32'($past(just.pos_det))) else $error("positive detected count off");
  AST_NEG_DET: assert property (clk_en |=>
    counts.neg_justify_detected_count == $past(counts.neg_justify_detected_count) +
    32'($past(just.neg_det))) else $error("negative detected count off");
  AST_POS_GEN: assert property (clk_en |=>
    counts.pos_justify_generated_count == $past(counts.pos_justify_generated_count) +
    32'($past(just.pos_gen))) else $error("positive generated count off");
  AST_NEG_GEN: assert property (clk_en |=>
    counts.neg_justify_generated_count == $past(counts.neg_justify_generated_count) +
    32'($past(just.neg_gen))) else $error("negative generated count off");
  AST_LINE_HOLD: assert property (clk_en && !line_in.rei_valid |=>
    $stable(counts.far_line.violation)) else $error("line violations moved without report");
  AST_FL_RDI: assert property (s_rdi_tick |-> s_line_judged)
    else $error("remote defect second not counted");
  AST_FL_FAIL: assert property (clk_en && $rose(line_in.rfi_failure) |=>
    counts.far_line.failure == $past(counts.far_line.failure) + 16'h0001)
    else $error("line failure onset not counted");
  AST_PATH_FREEZE: assert property (!intermediate_path_monitor_enable |=>
    $stable(counts.near_path) && $stable(counts.far_path))
    else $error("path counters moved while monitor off");
  AST_B3_CLAMP: assert property (clk_en && intermediate_path_monitor_enable &&
    near_path_in.b3_valid |=> counts.near_path.violation ==
    $past(counts.near_path.violation) + $past(b3_clamped)) else $error("path violations off");
  AST_ES_TICK: assert property ($changed(counts.near_path.errored) ||
    $changed(counts.far_line.errored) |-> $past(sec_tick)) else $error("errored moved off tick");
  AST_NP_UNAV: assert property ($changed(near_path_unavailable) |->
    $past(sec_tick, 2)) else $error("path availability moved off tick");
endmodule // pmc_counters_sva
`default_nettype wire

// File: pmc_oh_model.sv
// Overhead processor stand-in feeding frames, pulses, levels and ticks
`timescale 1ns/10ps
`default_nettype none
module pmc_oh_model (
  input wire logic ref_clk,
  output var pmc_pkg::pmc_just_t just,
  output var logic sec_tick,
  output var pmc_pkg::pmc_line_in_t line_in,
  output var pmc_pkg::pmc_path_in_t near_path_in,
  output var pmc_pkg::pmc_path_in_t far_path_in
);
  initial begin
    just = '0;
    sec_tick = 1'b0;
    line_in = '0;
    near_path_in = '0;
    far_path_in = '0;
  end
  task automatic justify(input int unsigned idx);
    @(negedge ref_clk);
    just[idx] = 1'b1;
    @(negedge ref_clk);
    just = '0;
  endtask
  task automatic rei_frame(input logic [7:0] n);
    @(negedge ref_clk);
    line_in.rei_valid = 1'b1;
    line_in.rei_count = n;
    @(negedge ref_clk);
    line_in.rei_valid = 1'b0;
    line_in.rei_count = ~n; // Stale count is garbage off frame
  endtask
  task automatic b3_frame(input logic [3:0] n);
    @(negedge ref_clk);
    near_path_in.b3_valid = 1'b1;
    near_path_in.b3_count = n;
    far_path_in.b3_valid = 1'b1;
    far_path_in.b3_count = n;
    @(negedge ref_clk);
    near_path_in.b3_valid = 1'b0;
    near_path_in.b3_count = ~n;
    far_path_in.b3_valid = 1'b0;
    far_path_in.b3_count = ~n;
  endtask
  task automatic line_lvl(input logic rdi, input logic rfi);
    @(negedge ref_clk);
    line_in.rdi_defect = rdi;
    line_in.rfi_failure = rfi;
  endtask
  // Defects and failures share the low seven bits of the carrier
  task automatic path_lvl(input logic [6:0] lv);
    @(negedge ref_clk);
    near_path_in[6:0] = lv;
    far_path_in[6:0] = lv;
  endtask
  // Gap after tick covers judge, tracker and count registers
  task automatic tick();
    @(negedge ref_clk);
    sec_tick = 1'b1;
    @(negedge ref_clk);
    sec_tick = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule // pmc_oh_model
`default_nettype wire

// File: tb_pmc_counters.sv
// Self-checking bench for the performance-monitoring counter block
`timescale 1ns/10ps
`default_nettype none
module tb_pmc_counters;
  logic ref_clk, reset, clk_en, oc48_mode, mon, sec_tick, fl_u, np_u, fp_u;
  logic [7:0] sts_n;
  logic [pmc_pkg::LINE_ACC_W-1:0] k;
  pmc_pkg::pmc_just_t just;
  pmc_pkg::pmc_line_in_t line_in;
  pmc_pkg::pmc_path_in_t near_in, far_in;
  pmc_pkg::pmc_counts_t counts;
  int errors = 0;
  int cmp_count = 0;
  pmc_oh_model oh_u (.ref_clk(ref_clk), .just(just), .sec_tick(sec_tick), .line_in(line_in),
    .near_path_in(near_in), .far_path_in(far_in));
  pmc_counters dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .sec_tick(sec_tick),
    .just(just), .oc48_mode(oc48_mode), .sts_n(sts_n), .line_in(line_in),
    .far_line_ses_threshold(k), .intermediate_path_monitor_enable(mon),
    .near_path_in(near_in), .far_path_in(far_in), .counts(counts),
    .far_line_unavailable(fl_u), .near_path_unavailable(np_u), .far_path_unavailable(fp_u));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_layer(input string w, input pmc_pkg::pmc_layer_cnt_t c,
    input logic [31:0] v, input logic [15:0] e, s, u, f);
    check({w, " violation"}, c.violation, v);
    check({w, " errored"}, 32'(c.errored), 32'(e));
    check({w, " severe"}, 32'(c.severe), 32'(s));
    check({w, " unavailable"}, 32'(c.unavailable), 32'(u));
    check({w, " failure"}, 32'(c.failure), 32'(f));
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Pulse counts differ per kind so a swapped field shows
  task automatic test_justify();
    for (int i = 0; i < 4; i++) begin
      repeat (i + 1) oh_u.justify(i);
    end
    check("pos detected", counts.pos_justify_detected_count, 32'h0000_0004);
    check("neg detected", counts.neg_justify_detected_count, 32'h0000_0003);
    check("pos generated", counts.pos_justify_generated_count, 32'h0000_0002);
    check("neg generated", counts.neg_justify_generated_count, 32'h0000_0001);
    // Enable low must swallow the pulse entirely
    clk_en = 1'b0;
    oh_u.justify(3);
    clk_en = 1'b1;
    check("frozen pos detected", counts.pos_justify_detected_count, 32'h0000_0004);
    $display("justify test done");
  endtask
  task automatic test_line();
    oh_u.rei_frame(8'h14);
    check("capped rei", counts.far_line.violation, 32'h0000_0010);
    oc48_mode = 1'b1;
    oh_u.rei_frame(8'hc8);
    oh_u.tick();
    chk_layer("far line", counts.far_line, 32'h0000_00d8, 16'h0001, 16'h0000, 16'h0000,
      16'h0000);
    oh_u.rei_frame(8'hff);
    oh_u.tick();
    check("below K", 32'(counts.far_line.severe), 32'h0000_0000);
    oh_u.rei_frame(8'hff);
    oh_u.rei_frame(8'h01);
    oh_u.tick();
    oh_u.line_lvl(1'b0, 1'b1);
    oh_u.line_lvl(1'b0, 1'b0);
    oh_u.line_lvl(1'b0, 1'b1);
    // Clean second breaks the run begun by the threshold second
    oh_u.tick();
    oh_u.line_lvl(1'b1, 1'b0);
    repeat (9) oh_u.tick();
    check("line avail at nine", 32'(fl_u), 32'h0000_0000);
    // Defect drops inside the tenth second, which still qualifies
    oh_u.line_lvl(1'b0, 1'b0);
    oh_u.tick();
    check("line unavail at ten", 32'(fl_u), 32'h0000_0001);
    repeat (10) oh_u.tick();
    check("line back", 32'(fl_u), 32'h0000_0000);
    chk_layer("far line end", counts.far_line, 32'h0000_02d7, 16'h000d, 16'h000b, 16'h000a,
      16'h0002);
    $display("line test done");
  endtask
  task automatic test_path();
    oh_u.b3_frame(4'h8);
    oh_u.path_lvl(7'h40);
    oh_u.tick();
    oh_u.path_lvl(7'h00);
    chk_layer("near off", counts.near_path, 32'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    mon = 1'b1;
    oh_u.b3_frame(4'hf);
    check("b3 clamp", counts.near_path.violation, 32'h0000_0008);
    repeat (298) oh_u.b3_frame(4'h8);
    oh_u.b3_frame(4'h7);
    oh_u.tick();
    repeat (300) oh_u.b3_frame(4'h8);
    oh_u.tick();
    for (int i = 0; i < 5; i++) begin
      oh_u.path_lvl(7'(1 << i));
      oh_u.path_lvl(7'h00);
    end
    oh_u.tick();
    oh_u.path_lvl(7'h20);
    repeat (9) oh_u.tick();
    check("path avail at nine", 32'(np_u), 32'h0000_0000);
    oh_u.path_lvl(7'h00);
    oh_u.tick();
    check("near unavail", 32'(np_u), 32'h0000_0001);
    check("far unavail", 32'(fp_u), 32'h0000_0001);
    repeat (10) oh_u.tick();
    check("paths back", 32'({np_u, fp_u}), 32'h0000_0000);
    chk_layer("near path", counts.near_path, 32'h0000_12bf, 16'h000c, 16'h000b, 16'h000a,
      16'h0005);
    chk_layer("far path", counts.far_path, 32'h0000_12bf, 16'h000c, 16'h000b, 16'h000a,
      16'h0005);
    $display("path test done");
  endtask
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    oc48_mode = 1'b0;
    mon = 1'b0;
    sts_n = 8'h02;
    k = 24'h00_0100;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    test_justify();
    test_line();
    test_path();
    give_verdict();
  end
  // Hang guard far beyond the whole sequence
  initial begin
    repeat (50000) @(posedge ref_clk);
    errors++;
    give_verdict();
  end
endmodule // tb_pmc_counters
bind pmc_counters pmc_counters_sva chk_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
  .sec_tick(sec_tick), .just(just), .line_in(line_in),
  .intermediate_path_monitor_enable(intermediate_path_monitor_enable),
  .near_path_in(near_path_in), .counts(counts), .near_path_unavailable(near_path_unavailable));
`default_nettype wire
